// >>> include/mbmi_regs.svh
`ifndef MBMI_REGS_SVH
`define MBMI_REGS_SVH

// memory-mapped holding register addresses
`define MBMI_ADDR_KEYPAD_REG   16'h0000
`define MBMI_ADDR_IOBOARD_REG  16'h2000
// decoder page size for external registers (one page per output)
`define MBMI_DEC_PAGE_LSB      13
// open-write window (writable without full-write enable): low 512 bytes
`define MBMI_WR_OPEN_LIMIT     13'h0200
// field positions
`define MBMI_PROG_HI_MSB       14
`define MBMI_PROG_HI_LSB       8
`define MBMI_DATA_HI_MSB       12
`define MBMI_DEC_EN_MSB        12
`define MBMI_DEC_EN_LSB        9
`define MBMI_TOP_BIT           15
// reset values
`define MBMI_LOW_ADDR_RST      8'h00
`define MBMI_HOLD_RST          8'h00
// controller clock, in hundredths of a hertz
`define MBMI_CTRL_CLK_CHZ      64'd1105920000

`endif

// >>> include/mbmi_pkg.sv
`default_nettype none

package mbmi_pkg;

  typedef enum logic [2:0] {
    MBMI_IDLE  = 3'b001,
    MBMI_ADDR  = 3'b010,
    MBMI_CYCLE = 3'b100
  } mbmi_phase_type;

  typedef logic [7:0]  mbmi_byte_type;
  typedef logic [15:0] mbmi_addr_type;

endpackage

`default_nettype wire

// >>> rtl/mbmi_hold_reg.sv
`timescale 1ns/1ps
`default_nettype none

`include "mbmi_regs.svh"

module mbmi_hold_reg
  import mbmi_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_sys_i,
  input  wire logic             rst_n_i,
  input  wire logic             wr_pulse_i,
  input  wire logic [WIDTH-1:0] data_i,
  output logic      [WIDTH-1:0] hold_o
);

  // capture the bus byte on the gated write pulse
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_o <= '0;
    end else if (wr_pulse_i) begin
      hold_o <= data_i;
    end
  end

endmodule

`default_nettype wire

// >>> rtl/mbmi_bridge.sv
// What this block does
// [R1] high address bits 8..14 pass straight to program memory upper inputs.
// [R2] top address bit reaches program memory via a separately overridable gate.
// [R3] low address byte captured on address strobe falling edge, then held.
// [R4] program fetch strobe low reads one byte from the addressed location.
// [R5] program space spans 64K bytes on the full sixteen-bit address.
// [R6] data memory is 8K bytes; each access follows an address setup.
// [R7] only address bits 8..12 go to the data memory upper inputs.
// [R8] low read or write pulse accesses one data memory byte.
// [R9] the bus byte is captured by the selected holding register on write.
// [R10] decoder maps both holding registers and external board registers.
// [R11] gated write pulse goes only to the register the address selects.
// [R12] controller bus timing runs from a nominal 11.0592 MHz clock.
// [R13] write to address zero selects the keypad/display holding register.
// [R14] write to hex 2000 selects the input/output board holding register.
// [R15] data writes need full-write enable low; the low 512-byte open window is decoder space.
// [R16] address bits 9..12 gate together to enable the decoder.
// [R17] low latch follows the bus while strobe high, holds after fall.
// [R18] after reset all strobes stay inactive until the first bus cycle.
`timescale 1ns/1ps
`default_nettype none

`include "mbmi_regs.svh"

module mbmi_bridge
  import mbmi_pkg::*;
#(
  parameter int           EXT_REGS     = 6,
  parameter logic [63:0]  CTRL_CLK_CHZ = `MBMI_CTRL_CLK_CHZ
) (
  input  wire logic                clk_sys_i,
  input  wire logic                rst_n_i,
  // controller side
  input  wire logic [7:0]          ad_i,
  input  wire logic [7:0]          high_addr_i,
  input  wire logic                addr_strobe_i,
  input  wire logic                program_fetch_strobe_n,
  input  wire logic                rd_n_i,
  input  wire logic                wr_n_i,
  output logic      [7:0]          ad_o,
  output logic                     ad_oe_o,
  // in-system reprogramming override of the top address bit
  input  wire logic                port_two_top_bit_ovr_en_i,
  input  wire logic                port_two_top_bit_ovr_i,
  input  wire logic                full_array_write_enable_n,
  // program memory
  output logic      [15:0]         prog_addr_o,
  output logic                     prog_oe_n_o,
  input  wire logic [7:0]          prog_data_i,
  // nonvolatile data memory
  output logic      [12:0]         data_addr_o,
  output logic                     data_rd_n_o,
  output logic                     data_wr_n_o,
  output logic      [7:0]          data_wdata_o,
  input  wire logic [7:0]          data_rdata_i,
  // holding registers and external board registers
  output logic      [7:0]          keypad_hold_o,
  output logic      [7:0]          ioboard_hold_o,
  output logic      [EXT_REGS-1:0] ext_wr_pulse_o,
  output logic      [7:0]          ext_wdata_o
);

  mbmi_phase_type phase_q;
  logic [7:0]     low_addr_q;
  logic           strobe_q;
  logic [15:0]    addr;
  logic [12:0]    data_addr;
  logic           dec_en;
  logic           wr_edge;
  logic           wr_n_q;
  logic           wr_protect_ok;
  logic           is_data;
  logic           sel_keypad;
  logic           sel_ioboard;
  logic [2:0]     page;
  logic [EXT_REGS-1:0] ext_sel;
  logic [7:0]     bus_byte;

  // bus timing reference; kept for derived timing checks
  localparam logic [63:0] CTRL_CLK_HZ = CTRL_CLK_CHZ / 64'd100; // R12

  // phase tracker: gates strobes until the first address strobe after reset
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_q <= MBMI_IDLE;
    end else begin
      case (phase_q)
        MBMI_IDLE:  if (addr_strobe_i) phase_q <= MBMI_ADDR; // R18
        MBMI_ADDR:  if (!addr_strobe_i) phase_q <= MBMI_CYCLE;
        MBMI_CYCLE: if (addr_strobe_i) phase_q <= MBMI_ADDR;
        default:    phase_q <= MBMI_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strobe_q <= 1'b0;
    end else begin
      strobe_q <= addr_strobe_i;
    end
  end

  // low address latch: follows while strobe high, frozen after fall
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_addr_q <= `MBMI_LOW_ADDR_RST;
    end else if (addr_strobe_i) begin
      low_addr_q <= ad_i; // R17
    end
  end

  // on the falling cycle the latch already holds the last high-phase byte
  assign addr = {high_addr_i, low_addr_q}; // R3

  // program memory address
  always_comb begin
    prog_addr_o = addr; // R5
    prog_addr_o[`MBMI_PROG_HI_MSB:`MBMI_PROG_HI_LSB] =
      high_addr_i[6:0]; // R1
    prog_addr_o[`MBMI_TOP_BIT] = port_two_top_bit_ovr_en_i ?
      port_two_top_bit_ovr_i : high_addr_i[7]; // R2
  end

  assign data_addr   = addr[`MBMI_DATA_HI_MSB:0]; // R7
  assign data_addr_o = data_addr; // R6

  wire active = (phase_q == MBMI_CYCLE);

  // fetch and data strobes only in an address-stable cycle
  assign prog_oe_n_o = !(active && !program_fetch_strobe_n); // R4
  assign data_rd_n_o = !(active && !rd_n_i && is_data); // R8

  // decoder enable from bits 9..12
  assign dec_en = (addr[`MBMI_DEC_EN_MSB:`MBMI_DEC_EN_LSB] == 4'h0); // R16
  assign page   = addr[15:`MBMI_DEC_PAGE_LSB];

  assign sel_keypad  = dec_en && (page == 3'd0); // R13
  assign sel_ioboard = dec_en &&
    (page == 3'(`MBMI_ADDR_IOBOARD_REG >> `MBMI_DEC_PAGE_LSB)); // R14
  assign is_data = !dec_en; // R10

  // data memory write protection
  assign wr_protect_ok = !full_array_write_enable_n ||
    (data_addr < `MBMI_WR_OPEN_LIMIT); // R15
  assign data_wr_n_o = !(active && !wr_n_i && is_data &&
    wr_protect_ok); // R8
  assign data_wdata_o = ad_i;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_n_q <= 1'b1;
    end else begin
      wr_n_q <= wr_n_i;
    end
  end

  // one pulse per write, at the strobe's falling edge
  assign wr_edge = active && !wr_n_i && wr_n_q;

  // external register pages 2 and up, one pulse line each
  always_comb begin
    ext_sel = '0;
    for (int i = 0; i < EXT_REGS; i++) begin
      if (dec_en && (32'(page) == i + 2)) begin
        ext_sel[i] = wr_edge; // R11
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_wr_pulse_o <= '0;
      ext_wdata_o    <= `MBMI_HOLD_RST;
    end else begin
      ext_wr_pulse_o <= ext_sel; // R11
      if (|ext_sel) begin
        ext_wdata_o <= ad_i; // R9
      end
    end
  end

  mbmi_hold_reg #(
    .WIDTH (8)
  ) u_keypad (
    .clk_sys_i  (clk_sys_i),
    .rst_n_i    (rst_n_i),
    .wr_pulse_i (wr_edge && sel_keypad), // R11
    .data_i     (ad_i), // R9
    .hold_o     (keypad_hold_o)
  );

  mbmi_hold_reg #(
    .WIDTH (8)
  ) u_ioboard (
    .clk_sys_i  (clk_sys_i),
    .rst_n_i    (rst_n_i),
    .wr_pulse_i (wr_edge && sel_ioboard), // R11
    .data_i     (ad_i), // R9
    .hold_o     (ioboard_hold_o)
  );

  // read data returned on the multiplexed bus, registered
  always_comb begin
    bus_byte = prog_data_i;
    if (!rd_n_i) begin
      bus_byte = data_rdata_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ad_o <= 8'h00;
    end else begin
      ad_o <= bus_byte; // R4
    end
  end

  assign ad_oe_o = active && (!program_fetch_strobe_n ||
    (!rd_n_i && is_data)); // R8

endmodule

`default_nettype wire

// >>> tb/mbmi_bridge_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module mbmi_bridge_asserts #(
  parameter int EXT_REGS = 6
) (
  input wire logic                clk_sys_i,
  input wire logic                rst_n_i,
  input wire logic [7:0]          ad_i,
  input wire logic [7:0]          high_addr_i,
  input wire logic                addr_strobe_i,
  input wire logic                program_fetch_strobe_n,
  input wire logic                wr_n_i,
  input wire logic                port_two_top_bit_ovr_en_i,
  input wire logic                port_two_top_bit_ovr_i,
  input wire logic                full_array_write_enable_n,
  input wire logic [15:0]         prog_addr_o,
  input wire logic                prog_oe_n_o,
  input wire logic                ad_oe_o,
  input wire logic [12:0]         data_addr_o,
  input wire logic                data_rd_n_o,
  input wire logic                data_wr_n_o,
  input wire logic [7:0]          ioboard_hold_o,
  input wire logic [EXT_REGS-1:0] ext_wr_pulse_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  logic seen_q;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) seen_q <= 1'b0;
    else if (addr_strobe_i) seen_q <= 1'b1;
  end
  AST_HI: assert property (prog_addr_o[14:8] == high_addr_i[6:0])
    else $error("high program address bits wrong");
  AST_TOP: assert property (prog_addr_o[15] ==
    (port_two_top_bit_ovr_en_i ? port_two_top_bit_ovr_i : high_addr_i[7]))
    else $error("top program address bit wrong");
  AST_LATCH: assert property ($past(addr_strobe_i) |->
    prog_addr_o[7:0] == $past(ad_i))
    else $error("low address latch wrong");
  AST_DADDR: assert property (data_addr_o ==
    {high_addr_i[4:0], prog_addr_o[7:0]})
    else $error("data memory address wrong");
  AST_FETCH: assert property (!prog_oe_n_o |->
    !program_fetch_strobe_n && ad_oe_o)
    else $error("program read without fetch strobe");
  AST_WLIM: assert property (!data_wr_n_o |-> !wr_n_i &&
    (data_addr_o < 13'h0200 || !full_array_write_enable_n))
    else $error("data write outside open window");
  AST_DEC: assert property (prog_addr_o[12:9] == 4'h0 |->
    data_wr_n_o && data_rd_n_o)
    else $error("data strobe in decoder space");
  AST_IOB: assert property ($fell(wr_n_i) &&
    prog_addr_o == 16'h2000 |-> ##[1:2] ioboard_hold_o == ad_i)
    else $error("io board register not written");
  AST_PULSE: assert property (|ext_wr_pulse_o |->
    $onehot(ext_wr_pulse_o) ##1 ext_wr_pulse_o == '0)
    else $error("external write pulse malformed");
  AST_IDLE: assert property (!seen_q |->
    prog_oe_n_o && data_rd_n_o && data_wr_n_o)
    else $error("strobe before first bus cycle");
  cover property (!prog_oe_n_o);
  cover property (!data_wr_n_o);
  cover property (|ext_wr_pulse_o);
endmodule
`default_nettype wire

// >>> tb/mbmi_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module mbmi_mem_model (
  input  wire logic [15:0] prog_addr_i,
  input  wire logic        prog_oe_n_i,
  input  wire logic [12:0] data_addr_i,
  input  wire logic        data_rd_n_i,
  input  wire logic        data_wr_n_i,
  input  wire logic [7:0]  wdata_i,
  output logic      [7:0]  prog_data_o,
  output logic      [7:0]  data_rdata_o
);
  logic [7:0] mem [0:8191];
  logic [7:0] pbyte;
  assign pbyte = prog_addr_i[15:8] ^ prog_addr_i[7:0] ^ 8'h5a;
  // released bus shows the inverse
  assign prog_data_o = prog_oe_n_i ? ~pbyte : pbyte;
  assign data_rdata_o = data_rd_n_i ? ~mem[data_addr_i] :
    mem[data_addr_i];
  initial for (int i = 0; i < 8192; i++) mem[i] = i[7:0];
  always @(posedge data_wr_n_i) mem[data_addr_i] = wdata_i;
endmodule
`default_nettype wire

// >>> tb/mbmi_bridge_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module mbmi_bridge_tb_top;
  import mbmi_pkg::*;
  logic clk_sys_i, rst_n_i, addr_strobe_i, program_fetch_strobe_n, rd_n_i;
  logic wr_n_i, port_two_top_bit_ovr_en_i, port_two_top_bit_ovr_i;
  logic full_array_write_enable_n, ad_oe_o, prog_oe_n_o, data_rd_n_o;
  logic data_wr_n_o;
  mbmi_byte_type ad_i, high_addr_i, ad_o, prog_data_i, data_wdata_o, q;
  mbmi_byte_type data_rdata_i, keypad_hold_o, ioboard_hold_o, ext_wdata_o;
  mbmi_addr_type prog_addr_o;
  logic [12:0] data_addr_o;
  logic [5:0]  ext_wr_pulse_o, pulse_seen;
  int n_mismatch, checks_done, cycles, n_pulse;
  mbmi_bridge #(.EXT_REGS(6)) u_dut (.clk_sys_i, .rst_n_i, .ad_i,
    .high_addr_i, .addr_strobe_i, .program_fetch_strobe_n, .rd_n_i, .wr_n_i,
    .ad_o, .ad_oe_o, .port_two_top_bit_ovr_en_i, .port_two_top_bit_ovr_i,
    .full_array_write_enable_n, .prog_addr_o, .prog_oe_n_o, .prog_data_i,
    .data_addr_o, .data_rd_n_o, .data_wr_n_o, .data_wdata_o, .data_rdata_i,
    .keypad_hold_o, .ioboard_hold_o, .ext_wr_pulse_o, .ext_wdata_o);
  mbmi_mem_model u_mem (.prog_addr_i(prog_addr_o), .prog_oe_n_i(prog_oe_n_o),
    .data_addr_i(data_addr_o), .data_rd_n_i(data_rd_n_o),
    .data_wr_n_i(data_wr_n_o), .wdata_i(data_wdata_o),
    .prog_data_o(prog_data_i), .data_rdata_o(data_rdata_i));
  initial begin
    clk_sys_i = 0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    n_pulse += (|ext_wr_pulse_o);
    pulse_seen = pulse_seen | ext_wr_pulse_o;
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      finish_test();
    end
  end
  task step(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // address phase, strobe 0 fetch, 1 read, 2 write, held three cycles
  task cyc(input mbmi_addr_type a, input int k, input mbmi_byte_type d);
    {high_addr_i, ad_i} = a;
    addr_strobe_i = 1;
    step(1);
    addr_strobe_i = 0;
    ad_i = d;
    step(1);
    case (k)
      0: program_fetch_strobe_n = 0;
      1: rd_n_i = 0;
      default: wr_n_i = 0;
    endcase
    step(3);
    q = ad_o;
    program_fetch_strobe_n = 1;
    rd_n_i = 1;
    wr_n_i = 1;
    step(1);
  endtask
  task t_idle;
    program_fetch_strobe_n = 0;
    step(2);
    chk(prog_oe_n_o, 16'h0001);
    chk(ad_oe_o, 16'h0000);
    program_fetch_strobe_n = 1;
    step(1);
    $display("test idle done");
  endtask
  task t_fetch;
    port_two_top_bit_ovr_en_i = 1;
    cyc(16'hffff, 0, 8'h00);
    chk(prog_addr_o, 16'h7fff);
    chk(q, 8'h7f ^ 8'hff ^ 8'h5a);
    port_two_top_bit_ovr_i = 1;
    cyc(16'h0102, 0, 8'h00);
    chk(prog_addr_o, 16'h8102);
    chk(q, 8'h81 ^ 8'h02 ^ 8'h5a);
    port_two_top_bit_ovr_en_i = 0;
    cyc(16'h8001, 0, 8'h00);
    chk(prog_addr_o, 16'h8001);
    chk(q, 8'h80 ^ 8'h01 ^ 8'h5a);
    $display("test fetch done");
  endtask
  task t_regs;
    cyc(16'h0000, 2, 8'h3c);
    chk(keypad_hold_o, 8'h3c);
    cyc(16'h2000, 2, 8'hc3);
    chk(ioboard_hold_o, 8'hc3);
    chk(keypad_hold_o, 8'h3c);
    cyc(16'h4000, 2, 8'h55);
    chk(n_pulse, 16'h0001);
    chk(pulse_seen, 16'h0001);
    chk(ext_wdata_o, 16'h0055);
    $display("test registers done");
  endtask
  task t_data;
    full_array_write_enable_n = 1;
    cyc(16'h1234, 2, 8'h99);
    cyc(16'h1234, 1, 8'h00);
    chk(q, 8'h34);
    full_array_write_enable_n = 0;
    cyc(16'h1234, 2, 8'h99);
    cyc(16'h3234, 1, 8'h00);
    chk(q, 8'h99);
    $display("test data memory done");
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    {rst_n_i, addr_strobe_i, ad_i, high_addr_i} = '0;
    {program_fetch_strobe_n, rd_n_i, wr_n_i} = 3'h7;
    {port_two_top_bit_ovr_en_i, port_two_top_bit_ovr_i} = 2'h0;
    full_array_write_enable_n = 1;
    pulse_seen = '0;
    step(12);
    rst_n_i = 1;
    t_idle();
    t_fetch();
    t_regs();
    t_data();
    finish_test();
  end
endmodule
bind mbmi_bridge mbmi_bridge_asserts #(.EXT_REGS(EXT_REGS)) u_chk (
  .clk_sys_i, .rst_n_i, .ad_i, .high_addr_i, .addr_strobe_i,
  .program_fetch_strobe_n, .wr_n_i, .port_two_top_bit_ovr_en_i,
  .port_two_top_bit_ovr_i, .full_array_write_enable_n, .prog_addr_o,
  .prog_oe_n_o, .ad_oe_o, .data_addr_o, .data_rd_n_o, .data_wr_n_o,
  .ioboard_hold_o, .ext_wr_pulse_o);
`default_nettype wire
